// ### logic/afp_decoder.v
`include "afp_defs.vh"

// How it works
// - EF in command register runs subcommand from feature, setting from sector count.
// - 01H selects byte-wide transfers, 81H leaves; 16-bit indicator off meanwhile.
// - 02H enables write cache, 82H disables after flushing cached data.
// - subcommand 03H takes transfer mode from sector count value.
// - bits 7:3 type, 2:0 mode; PIO default, flow PIO, MDMA, UDMA; rest reserved.
// - exactly one PIO mode is always selected; later commands may change it.
// - 05H enables advanced power management, 85H disables it.
// - 09H enables extended power operations, 89H disables them.
// - 55H disables read look-ahead (default), AAH enables it.
// - 66H keeps settings across software reset, CCH restores defaults there.
// - subcommands 69H, 96H and 97H are accepted as no-operations.
// - idle opcodes 97/E3 set busy, enter idle, clear busy, interrupt.
// - idle with nonzero count loads auto power-down timer in 5 ms units.
// - idle with zero count enables power-down with three 5 ms units.
// - sleep opcodes 99/E6 set busy, enter sleep, clear busy, interrupt.
// - any further command addressed to this device wakes it from sleep.
// - inactivity timer expiry enters sleep; default timer is 15 ms.
// - opcode 8B with AAH selects write-protect, 55H power-down pin function.
// - pin function defaults to write-protect from the factory.
// - pin command needs keys 6E,44,72,50 else it is invalid.
// - pin function is stored persistently; only the pin command changes it.
module afp_decoder #(
  parameter UNIT_CYC = `AFP_UNIT_CYC
) (
  input wire mclk_i,
  input wire nrst_i,
  input wire [2:0] tf_addr_i,
  input wire [7:0] tf_wdata_i,
  input wire tf_wr_i,
  input wire tf_rd_i,
  output reg [7:0] tf_rdata_o,
  input wire dev_num_i,
  input wire srst_i,
  input wire flush_done_i,
  input wire nv_func_i,
  output reg intrq_o,
  output wire busy_o,
  output reg flush_req_o,
  output wire byte_mode_o,
  output wire iocs16_en_o,
  output wire wcache_en_o,
  output wire rla_en_o,
  output wire apm_en_o,
  output wire epo_en_o,
  output wire keep_settings_o,
  output wire [2:0] pio_mode_o,
  output wire iordy_dis_o,
  output wire mdma_en_o,
  output wire udma_en_o,
  output wire [2:0] dma_mode_o,
  output wire idle_o,
  output wire sleep_o,
  output wire autopd_en_o,
  output wire pin_func_wp_o,
  output wire nv_we_o,
  output wire nv_wdata_o
);
  localparam S_RDY = 3'b001;
  localparam S_EXEC = 3'b010;
  localparam S_FLUSH = 3'b100;
  localparam integer UNIT_LAST_I = UNIT_CYC - 1;
  localparam [16:0] UNIT_LAST = UNIT_LAST_I[16:0];

  // pins from the host side, two stages before use
  reg [15:0] pin_s1, pin_s2;
  reg wr_d_r, rd_d_r, srst_d_r;
  wire [2:0] a_s = pin_s2[2:0];
  wire [7:0] d_s = pin_s2[10:3];
  wire wr_s = pin_s2[11];
  wire rd_s = pin_s2[12];
  wire dev_s = pin_s2[13];
  wire srst_s = pin_s2[14];
  wire fdone_s = pin_s2[15];
  wire wr_p = wr_s & ~wr_d_r;
  wire rd_p = rd_s & ~rd_d_r;
  wire srst_p = srst_s & ~srst_d_r;
  reg nv_s1, nv_s2;

  always @(posedge mclk_i) begin
    pin_s1 <= {flush_done_i, srst_i, dev_num_i, tf_rd_i, tf_wr_i, tf_wdata_i, tf_addr_i};
    pin_s2 <= pin_s1;
    nv_s1 <= nv_func_i;
    nv_s2 <= nv_s1;
  end

  reg [2:0] state_r;
  reg [7:0] feat_r, scnt_r, snum_r, cyll_r, cylh_r, drvh_r, cmd_r;
  reg abrt_r, byte_r, wc_r, rla_r, apm_r, epo_r, keep_r;
  reg [2:0] pio_r;
  reg iordy_dis_r, mdma_r, udma_r;
  reg [2:0] dmam_r;
  reg idle_r, sleep_r, autopd_r;
  reg [7:0] reload_r, units_r;
  reg [16:0] pre_r;
  reg pin_we, pin_wd;
  wire pin_q;

  wire [4:0] xtype = scnt_r[7:3];
  wire [2:0] xmode = scnt_r[2:0];
  wire key_ok = (cylh_r == `AFP_KEY_CYLH) && (cyll_r == `AFP_KEY_CYLL) &&
    (snum_r == `AFP_KEY_SNUM) && (scnt_r == `AFP_KEY_SCNT);
  wire busy = ~state_r[0];
  wire cmd_wr = wr_p && (a_s == `AFP_REG_CMD) && !busy;
  wire drv_hit = (drvh_r[`AFP_DRV_BIT] == dev_s);
  wire unit_end = (pre_r == UNIT_LAST);
  wire is_idle = (cmd_r == `AFP_OP_IDLE_A) || (cmd_r == `AFP_OP_IDLE_B);
  wire is_slp = (cmd_r == `AFP_OP_SLP_A) || (cmd_r == `AFP_OP_SLP_B);
  wire [7:0] status = {busy, ~busy, 1'b0, 1'b1, 3'h0, abrt_r};
  wire [7:0] errreg = {5'h00, abrt_r, 2'h0};

  // parameter registers; host writes ignored while busy
  always @(posedge mclk_i) begin
    if (!nrst_i) begin
      feat_r <= 8'h00;
      scnt_r <= 8'h01;
      snum_r <= 8'h01;
      cyll_r <= 8'h00;
      cylh_r <= 8'h00;
      drvh_r <= 8'h00;
      cmd_r <= 8'h00;
    end else if (wr_p && !busy) begin
      case (a_s)
        `AFP_REG_FEAT: feat_r <= d_s;
        `AFP_REG_SCNT: scnt_r <= d_s;
        `AFP_REG_SNUM: snum_r <= d_s;
        `AFP_REG_CYLL: cyll_r <= d_s;
        `AFP_REG_CYLH: cylh_r <= d_s;
        `AFP_REG_DRVH: drvh_r <= d_s;
        `AFP_REG_CMD: cmd_r <= d_s;
        default: cmd_r <= cmd_r;
      endcase
    end
  end

  // read data, registered; status read acknowledges the interrupt
  always @(posedge mclk_i) begin
    if (!nrst_i) begin
      tf_rdata_o <= 8'h00;
    end else if (rd_p) begin
      case (a_s)
        `AFP_REG_FEAT: tf_rdata_o <= errreg;
        `AFP_REG_SCNT: tf_rdata_o <= scnt_r;
        `AFP_REG_SNUM: tf_rdata_o <= snum_r;
        `AFP_REG_CYLL: tf_rdata_o <= cyll_r;
        `AFP_REG_CYLH: tf_rdata_o <= cylh_r;
        `AFP_REG_DRVH: tf_rdata_o <= drvh_r;
        `AFP_REG_CMD: tf_rdata_o <= status;
        default: tf_rdata_o <= 8'h00;
      endcase
    end
  end

  // command sequencer and feature state
  always @(posedge mclk_i) begin
    if (!nrst_i) begin
      state_r <= S_RDY;
      wr_d_r <= 1'b0;
      rd_d_r <= 1'b0;
      srst_d_r <= 1'b0;
      intrq_o <= 1'b0;
      flush_req_o <= 1'b0;
      abrt_r <= 1'b0;
      byte_r <= 1'b0;
      wc_r <= 1'b0;
      rla_r <= 1'b0;
      apm_r <= 1'b0;
      epo_r <= 1'b0;
      keep_r <= 1'b0;
      pio_r <= 3'h0;
      iordy_dis_r <= 1'b0;
      mdma_r <= 1'b0;
      udma_r <= 1'b0;
      dmam_r <= 3'h0;
      idle_r <= 1'b0;
      sleep_r <= 1'b0;
      autopd_r <= 1'b1;
      reload_r <= `AFP_IDLE_DEF_UNITS;
      units_r <= `AFP_IDLE_DEF_UNITS;
      pre_r <= 17'h00000;
      pin_we <= 1'b0;
      pin_wd <= `AFP_PIN_WP;
    end else begin
      wr_d_r <= wr_s;
      rd_d_r <= rd_s;
      srst_d_r <= srst_s;
      pin_we <= 1'b0;
      // set wins over the status-read acknowledge
      if (rd_p && (a_s == `AFP_REG_CMD))
        intrq_o <= 1'b0;
      // inactivity timer runs only while ready and awake
      if (cmd_wr) begin
        pre_r <= 17'h00000;
        units_r <= reload_r;
      end else if (!busy && !sleep_r && autopd_r) begin
        pre_r <= unit_end ? 17'h00000 : pre_r + 17'h00001;
        if (unit_end) begin
          if (units_r <= 8'h01) begin
            sleep_r <= 1'b1;
            idle_r <= 1'b0;
            units_r <= reload_r;
          end else begin
            units_r <= units_r - 8'h01;
          end
        end
      end
      // software reset; settings survive when retention is on
      if (srst_p && !busy && !keep_r) begin
        byte_r <= 1'b0;
        wc_r <= 1'b0;
        rla_r <= 1'b0;
        apm_r <= 1'b0;
        epo_r <= 1'b0;
        pio_r <= 3'h0;
        iordy_dis_r <= 1'b0;
        mdma_r <= 1'b0;
        udma_r <= 1'b0;
        dmam_r <= 3'h0;
      end
      case (state_r)
        S_RDY: begin
          // other device's commands start no execution here, but still restart the inactivity timer
          if (cmd_wr && (drvh_r[`AFP_DRV_BIT] == dev_s)) begin
            state_r <= S_EXEC;
            abrt_r <= 1'b0;
            sleep_r <= 1'b0;
          end
        end
        S_EXEC: begin
          state_r <= S_RDY;
          intrq_o <= 1'b1;
          if (!drv_hit) begin
            intrq_o <= 1'b0;
          end else if (cmd_r == `AFP_OP_SETF) begin
            case (feat_r)
              `AFP_SF_BYTE_ON: byte_r <= 1'b1;
              `AFP_SF_BYTE_OFF: byte_r <= 1'b0;
              `AFP_SF_WC_ON: wc_r <= 1'b1;
              `AFP_SF_WC_OFF: begin
                // completion waits for the flush to finish
                if (wc_r) begin
                  state_r <= S_FLUSH;
                  flush_req_o <= 1'b1;
                  intrq_o <= 1'b0;
                end
              end
              `AFP_SF_XFER: begin
                case (xtype)
                  `AFP_XT_PIODEF: begin
                    if (xmode == `AFP_XM_DEF || xmode == `AFP_XM_NOIORDY) begin
                      pio_r <= 3'h0;
                      iordy_dis_r <= (xmode == `AFP_XM_NOIORDY);
                    end else begin
                      abrt_r <= 1'b1;
                    end
                  end
                  `AFP_XT_PIOFC: begin
                    pio_r <= xmode;
                    iordy_dis_r <= 1'b0;
                  end
                  `AFP_XT_MDMA: begin
                    mdma_r <= 1'b1;
                    udma_r <= 1'b0;
                    dmam_r <= xmode;
                  end
                  `AFP_XT_UDMA: begin
                    udma_r <= 1'b1;
                    mdma_r <= 1'b0;
                    dmam_r <= xmode;
                  end
                  default: abrt_r <= 1'b1;
                endcase
              end
              `AFP_SF_APM_ON: apm_r <= 1'b1;
              `AFP_SF_APM_OFF: apm_r <= 1'b0;
              `AFP_SF_EPO_ON: epo_r <= 1'b1;
              `AFP_SF_EPO_OFF: epo_r <= 1'b0;
              `AFP_SF_RLA_OFF: rla_r <= 1'b0;
              `AFP_SF_RLA_ON: rla_r <= 1'b1;
              `AFP_SF_KEEP_ON: keep_r <= 1'b1;
              `AFP_SF_KEEP_OFF: keep_r <= 1'b0;
              `AFP_SF_NOP_A: abrt_r <= 1'b0;
              `AFP_SF_NOP_B: abrt_r <= 1'b0;
              `AFP_SF_LEGACY: abrt_r <= 1'b0;
              default: abrt_r <= 1'b1;
            endcase
          end else if (is_idle) begin
            idle_r <= 1'b1;
            autopd_r <= 1'b1;
            pre_r <= 17'h00000;
            if (scnt_r != 8'h00) begin
              reload_r <= scnt_r;
              units_r <= scnt_r;
            end else begin
              reload_r <= `AFP_IDLE_DEF_UNITS;
              units_r <= `AFP_IDLE_DEF_UNITS;
            end
          end else if (is_slp) begin
            sleep_r <= 1'b1;
            idle_r <= 1'b0;
          end else if (cmd_r == `AFP_OP_PINCFG) begin
            // key mismatch is an invalid command
            if (key_ok && feat_r == `AFP_PF_WP) begin
              pin_we <= 1'b1;
              pin_wd <= 1'b1;
            end else if (key_ok && feat_r == `AFP_PF_PD) begin
              pin_we <= 1'b1;
              pin_wd <= 1'b0;
            end else begin
              abrt_r <= 1'b1;
            end
          end else begin
            abrt_r <= 1'b1;
          end
        end
        S_FLUSH: begin
          // busy holds until storage confirms the flush
          if (fdone_s) begin
            flush_req_o <= 1'b0;
            wc_r <= 1'b0;
            state_r <= S_RDY;
            intrq_o <= 1'b1;
          end
        end
        default: state_r <= S_RDY;
      endcase
    end
  end

  afp_nv_cell u_pin_cell (
    .mclk_i(mclk_i),
    .nrst_i(nrst_i),
    .nv_i(nv_s2),
    .we_i(pin_we),
    .wdata_i(pin_wd),
    .q_o(pin_q),
    .nv_we_o(nv_we_o),
    .nv_wdata_o(nv_wdata_o)
  );

  assign busy_o = busy;
  assign byte_mode_o = byte_r;
  assign iocs16_en_o = ~byte_r;
  assign wcache_en_o = wc_r;
  assign rla_en_o = rla_r;
  assign apm_en_o = apm_r;
  assign epo_en_o = epo_r;
  assign keep_settings_o = keep_r;
  assign pio_mode_o = pio_r;
  assign iordy_dis_o = iordy_dis_r;
  assign mdma_en_o = mdma_r;
  assign udma_en_o = udma_r;
  assign dma_mode_o = dmam_r;
  assign idle_o = idle_r;
  assign sleep_o = sleep_r;
  assign autopd_en_o = autopd_r;
  assign pin_func_wp_o = pin_q;
endmodule // afp_decoder

// ### logic/afp_defs.vh
`ifndef AFP_DEFS_VH
`define AFP_DEFS_VH
// task-file register offsets
`define AFP_REG_FEAT 3'h1
`define AFP_REG_SCNT 3'h2
`define AFP_REG_SNUM 3'h3
`define AFP_REG_CYLL 3'h4
`define AFP_REG_CYLH 3'h5
`define AFP_REG_DRVH 3'h6
`define AFP_REG_CMD 3'h7
`define AFP_DRV_BIT 4
// opcodes
`define AFP_OP_SETF 8'hEF
`define AFP_OP_IDLE_A 8'h97
`define AFP_OP_IDLE_B 8'hE3
`define AFP_OP_SLP_A 8'h99
`define AFP_OP_SLP_B 8'hE6
`define AFP_OP_PINCFG 8'h8B
// set-features subcommands
`define AFP_SF_BYTE_ON 8'h01
`define AFP_SF_BYTE_OFF 8'h81
`define AFP_SF_WC_ON 8'h02
`define AFP_SF_WC_OFF 8'h82
`define AFP_SF_XFER 8'h03
`define AFP_SF_APM_ON 8'h05
`define AFP_SF_APM_OFF 8'h85
`define AFP_SF_EPO_ON 8'h09
`define AFP_SF_EPO_OFF 8'h89
`define AFP_SF_RLA_OFF 8'h55
`define AFP_SF_RLA_ON 8'hAA
`define AFP_SF_KEEP_ON 8'h66
`define AFP_SF_KEEP_OFF 8'hCC
`define AFP_SF_NOP_A 8'h69
`define AFP_SF_NOP_B 8'h96
`define AFP_SF_LEGACY 8'h97
// transfer type field, sector count bits 7:3
`define AFP_XT_PIODEF 5'h00
`define AFP_XT_PIOFC 5'h01
`define AFP_XT_MDMA 5'h04
`define AFP_XT_UDMA 5'h08
`define AFP_XM_DEF 3'h0
`define AFP_XM_NOIORDY 3'h1
// pin-configuration key and function values
`define AFP_KEY_CYLH 8'h6E
`define AFP_KEY_CYLL 8'h44
`define AFP_KEY_SNUM 8'h72
`define AFP_KEY_SCNT 8'h50
`define AFP_PF_WP 8'hAA
`define AFP_PF_PD 8'h55
`define AFP_PIN_WP 1'h1
// status and error bits
`define AFP_ST_BSY 7
`define AFP_ST_DRDY 6
`define AFP_ST_DSC 4
`define AFP_ST_ERR 0
`define AFP_ER_ABRT 2
// timing
`define AFP_CLK_HZ 25000000
`define AFP_UNIT_MS 5
`define AFP_UNIT_CYC (`AFP_CLK_HZ / 1000 * `AFP_UNIT_MS)
`define AFP_IDLE_DEF_UNITS 8'h03
`endif

// ### logic/afp_nv_cell.v
`include "afp_defs.vh"

// one bit of persistent pin function; external storage mirrors it
module afp_nv_cell (
  input wire mclk_i,
  input wire nrst_i,
  input wire nv_i,
  input wire we_i,
  input wire wdata_i,
  output wire q_o,
  output reg nv_we_o,
  output reg nv_wdata_o
);
  reg q_r;
  reg loaded_r;

  always @(posedge mclk_i) begin
    if (!nrst_i) begin
      // follow storage so a reset never flips the pin function
      q_r <= nv_i;
      loaded_r <= 1'b0;
      nv_we_o <= 1'b0;
      nv_wdata_o <= `AFP_PIN_WP;
    end else begin
      nv_we_o <= we_i;
      if (we_i) begin
        q_r <= wdata_i;
        nv_wdata_o <= wdata_i;
        loaded_r <= 1'b1;
      end else if (!loaded_r) begin
        // reset must not change the stored function, so reload it
        q_r <= nv_i;
        loaded_r <= 1'b1;
      end
    end
  end

  assign q_o = q_r;
endmodule // afp_nv_cell

// ### sim/afp_checker.sv
module afp_checker (
  input wire mclk_i,
  input wire nrst_i,
  input wire busy_o,
  input wire intrq_o,
  input wire flush_req_o,
  input wire byte_mode_o,
  input wire iocs16_en_o,
  input wire wcache_en_o,
  input wire mdma_en_o,
  input wire udma_en_o,
  input wire pin_func_wp_o,
  input wire nv_we_o,
  input wire nv_wdata_o
);
  default clocking @(posedge mclk_i);
  endclocking
  default disable iff (!nrst_i);
  sequence cmd_start;
    $rose(busy_o) ##1 !flush_req_o;
  endsequence
  sequence nv_store;
    nv_we_o && nv_wdata_o == pin_func_wp_o;
  endsequence
  chk_busy_short: assert property (cmd_start |-> !busy_o)
    else $error("busy held past one cycle");
  chk_end_intr: assert property ($fell(busy_o) |-> intrq_o)
    else $error("no interrupt at command end");
  chk_byte_iocs: assert property (iocs16_en_o == !byte_mode_o)
    else $error("16-bit indicator wrong");
  chk_flush_wait: assert property (flush_req_o |-> busy_o && wcache_en_o)
    else $error("completion before flush");
  chk_flush_end: assert property ($fell(flush_req_o) |-> !busy_o && intrq_o && !wcache_en_o)
    else $error("flush end wrong");
  chk_dma_one: assert property (!(mdma_en_o && udma_en_o))
    else $error("two dma kinds selected");
  chk_nv_pulse: assert property (nv_we_o |-> nv_store ##1 !nv_we_o)
    else $error("store pulse wrong");
  chk_pin_hold: assert property ($changed(pin_func_wp_o) && $past(nrst_i) |-> nv_we_o)
    else $error("pin function changed without store");
endmodule // afp_checker

bind afp_decoder afp_checker i_chk (.*);

// ### sim/afp_host_model.sv
module afp_host_model (
  input wire logic mclk_i,
  input wire logic flush_req_o,
  input wire logic nv_we_o,
  input wire logic nv_wdata_o,
  input wire logic [7:0] tf_rdata_o,
  output logic [2:0] tf_addr_i,
  output logic [7:0] tf_wdata_i,
  output logic tf_wr_i,
  output logic tf_rd_i,
  output logic flush_done_i,
  output logic nv_func_i
);
  timeunit 1ns;
  timeprecision 1ns;
  int flush_lag = 8;
  int lag_cnt = 0;
  initial begin
    tf_addr_i = 3'h7;
    tf_wdata_i = 8'h00;
    tf_wr_i = 1'b0;
    tf_rd_i = 1'b0;
    flush_done_i = 1'b0;
    nv_func_i = 1'b1;
  end
  // persistent store outlives any device reset
  always @(posedge mclk_i) begin
    if (nv_we_o) nv_func_i <= nv_wdata_o;
    lag_cnt <= flush_req_o ? lag_cnt + 1 : 0;
    flush_done_i <= flush_req_o && lag_cnt >= flush_lag;
  end
  task automatic strobe(input logic [2:0] a, input logic [7:0] d, input logic rd);
    @(posedge mclk_i);
    #1;
    tf_addr_i = a;
    tf_wdata_i = d;
    tf_wr_i = !rd;
    tf_rd_i = rd;
    repeat (3) @(posedge mclk_i);
    #1;
    tf_wr_i = 1'b0;
    tf_rd_i = 1'b0;
    // released bus must not look like the last byte
    tf_wdata_i = ~d;
    repeat (3) @(posedge mclk_i);
  endtask
  task automatic issue(input logic [7:0] op, input logic [7:0] f, input logic [7:0] cnt,
      input logic [7:0] drv);
    strobe(3'h1, f, 1'b0);
    strobe(3'h2, cnt, 1'b0);
    strobe(3'h6, drv, 1'b0);
    strobe(3'h7, op, 1'b0);
  endtask
endmodule // afp_host_model

// ### sim/test_afp_decoder.sv
`define CHK(nm, e, g) begin comparisons++; if ((g) !== (e)) begin n_errors++; \
  $display("[FAIL] %s expected %h seen %h", nm, e, g); end end

module test_afp_decoder;
  timeunit 1ns;
  timeprecision 1ns;
  logic mclk_i = 0, nrst_i = 0, dev_num_i = 0, srst_i = 0;
  wire [2:0] tf_addr_i, pio_mode_o, dma_mode_o;
  wire [7:0] tf_wdata_i, tf_rdata_o;
  wire tf_wr_i, tf_rd_i, flush_done_i, nv_func_i, intrq_o, busy_o, flush_req_o, byte_mode_o;
  wire iocs16_en_o, wcache_en_o, rla_en_o, apm_en_o, epo_en_o, keep_settings_o, iordy_dis_o;
  wire mdma_en_o, udma_en_o, idle_o, sleep_o, autopd_en_o, pin_func_wp_o, nv_we_o, nv_wdata_o;
  int n_errors = 0;
  int comparisons = 0;
  int cycles = 0;
  logic [7:0] st;
  localparam logic [7:0] ON_C [6] = '{8'h01, 8'h05, 8'h09, 8'hAA, 8'h66, 8'h02};
  localparam logic [7:0] OFF_C [6] = '{8'h81, 8'h85, 8'h89, 8'h55, 8'hCC, 8'h82};
  localparam logic [7:0] NOP_C [4] = '{8'h69, 8'h96, 8'h97, 8'h33};
  localparam logic [7:0] XF_CNT [6] = '{8'h0B, 8'h22, 8'h45, 8'h18, 8'h01, 8'h00};
  // {abort, pio, iordy off, mdma, udma, dma mode}
  localparam logic [9:0] XF_EXP [6] = '{10'h0C0, 10'h0D2, 10'h0CD, 10'h2CD, 10'h02D, 10'h00D};
  localparam logic [7:0] PIN_F [3] = '{8'h55, 8'hAA, 8'h55};
  localparam logic [1:0] PIN_E [3] = '{2'h3, 2'h2, 2'h0};

  afp_decoder #(.UNIT_CYC(20)) i_dut (.*);
  afp_host_model i_host (.*);

  initial begin
    forever #20 mclk_i = ~mclk_i;
  end
  always @(posedge mclk_i) begin
    cycles++;
    if (cycles == 20000) begin
      n_errors++;
      stop_test;
    end
  end

  task stop_test;
    if (n_errors == 0 && comparisons > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask

  function automatic logic flag(int i);
    return i == 0 ? byte_mode_o : i == 1 ? apm_en_o : i == 2 ? epo_en_o : i == 3 ? rla_en_o :
      i == 4 ? keep_settings_o : wcache_en_o;
  endfunction

  task automatic run(input logic [7:0] op, input logic [7:0] f, input logic [7:0] cnt,
      input logic [7:0] drv);
    int n;
    i_host.issue(op, f, cnt, drv);
    for (n = 0; n < 60 && intrq_o !== 1'b1; n++) @(posedge mclk_i);
    `CHK("intrq", 1'b1, intrq_o)
    i_host.strobe(3'h7, 8'h00, 1'b1);
    st = tf_rdata_o;
    `CHK("intrq clear", 1'b0, intrq_o)
  endtask

  task t_defaults;
    @(posedge mclk_i);
    `CHK("defaults", 3'b011, {rla_en_o, pin_func_wp_o, autopd_en_o})
  endtask

  task t_flags;
    for (int i = 0; i < 6; i++) begin
      run(8'hEF, ON_C[i], 8'h00, 8'h00);
      `CHK("flag on", 9'h150, {flag(i), st})
      run(8'hEF, OFF_C[i], 8'h00, 8'h00);
      `CHK("flag off", 9'h050, {flag(i), st})
    end
    foreach (NOP_C[i]) begin
      run(8'hEF, NOP_C[i], 8'h00, 8'h00);
      `CHK("nop status", i == 3 ? 8'h51 : 8'h50, st)
      i_host.strobe(3'h1, 8'h00, 1'b1);
      `CHK("error reg", i == 3 ? 8'h04 : 8'h00, tf_rdata_o)
    end
  endtask

  task t_xfer;
    foreach (XF_CNT[i]) begin
      run(8'hEF, 8'h03, XF_CNT[i], 8'h00);
      `CHK("xfer", XF_EXP[i], {st[0], pio_mode_o, iordy_dis_o, mdma_en_o, udma_en_o, dma_mode_o})
    end
  endtask

  task t_drive;
    i_host.issue(8'hEF, 8'hAA, 8'h00, 8'h10);
    repeat (20) @(posedge mclk_i);
    `CHK("foreign drive", 2'b00, {intrq_o, rla_en_o})
    #1 dev_num_i = 1'b1;
    run(8'hEF, 8'hAA, 8'h00, 8'h10);
    `CHK("own drive", 1'b1, rla_en_o)
    run(8'hEF, 8'h55, 8'h00, 8'h10);
    #1 dev_num_i = 1'b0;
  endtask

  task t_power;
    int n;
    for (int i = 0; i < 2; i++) begin
      run(i ? 8'h99 : 8'hE6, 8'h00, 8'h00, 8'h00);
      `CHK("sleep", 3'b010, {idle_o, sleep_o, st[0]})
      run(8'hEF, 8'h69, 8'h00, 8'h00);
      `CHK("wake", 1'b0, sleep_o)
    end
    for (int i = 0; i < 2; i++) begin
      // 2 units then the default of 3 units, 20 cycles each
      run(i ? 8'hE3 : 8'h97, 8'h00, i ? 8'h00 : 8'h02, 8'h00);
      `CHK("idle", 3'b110, {idle_o, autopd_en_o, sleep_o})
      repeat (i ? 40 : 20) @(posedge mclk_i);
      `CHK("timer early", 1'b0, sleep_o)
      for (n = 0; n < 40 && sleep_o !== 1'b1; n++) @(posedge mclk_i);
      `CHK("timer expiry", 1'b1, sleep_o)
    end
  endtask

  task t_srst;
    for (int i = 0; i < 2; i++) begin
      run(8'hEF, i ? 8'h66 : 8'hCC, 8'h00, 8'h00);
      run(8'hEF, 8'hAA, 8'h00, 8'h00);
      #1 srst_i = 1'b1;
      repeat (3) @(posedge mclk_i);
      #1 srst_i = 1'b0;
      repeat (8) @(posedge mclk_i);
      `CHK("rla after soft reset", i[0], rla_en_o)
    end
  endtask

  task t_pin;
    foreach (PIN_F[i]) begin
      i_host.strobe(3'h5, 8'h6E, 1'b0);
      i_host.strobe(3'h4, 8'h44, 1'b0);
      i_host.strobe(3'h3, i == 0 ? 8'h73 : 8'h72, 1'b0);
      run(8'h8B, PIN_F[i], 8'h50, 8'h00);
      `CHK("pin function", PIN_E[i], {pin_func_wp_o, st[0]})
    end
    #1 nrst_i = 1'b0;
    repeat (4) @(posedge mclk_i);
    `CHK("pin in reset", 1'b0, pin_func_wp_o)
    #1 nrst_i = 1'b1;
    repeat (3) @(posedge mclk_i);
    `CHK("pin after reset", 1'b0, pin_func_wp_o)
  endtask

  initial begin
    repeat (8) @(posedge mclk_i);
    #1 nrst_i = 1'b1;
    t_defaults;
    t_flags;
    t_xfer;
    t_drive;
    t_power;
    t_srst;
    t_pin;
    stop_test;
  end
endmodule // test_afp_decoder
